/* hdl/sfio_front.sv */
// Serial front end of a serial flash: mode control, command capture, pause and resets.
// Assumes a host drives chip select, clock and data; array and status logic sit outside.
// How it works
// - Single mode: input bits sampled on rising clock
// - Single mode: output changes on falling clock
// - Dual/quad share data lines, same edges
// - Quad needs quad enable; pins become lines
// - Write-protect blocks status writes unless quad
// - Pause tristates output, ignores input and clock
// - Pause changes at pin edge when clock low
// - Pause only in single/dual, quad enable clear
// - Clock modes 0 and 3 supported
// - 3Bh and BBh are dual reads
// - 6Bh and EBh are quad reads
// - 38h enters, FFh exits four-wire mode
// - Four-wire opcode in two clocks, else eight
// - Modes exclusive; start and reset in SPI
// - 66h then 99h resets, busy 30us
// - Select bit makes shared pin pause or reset
// - Reset held 1us restores power-on state
// - Quad enable disables pause and reset pin
// - Dedicated reset pin always works
// - Hardware reset overrides all inputs but those of the status write block
// - Deselected means outputs released; needs select fall
`timescale 1ns/100ps
`include "sfio_defines.svh"
module sfio_front
  import sfio_pkg::*;
#(
  parameter int SW_RST_CYC = `SFIO_SW_RST_CYC,
  parameter int HW_RST_CYC = `SFIO_HW_RST_CYC,
  parameter int ADDR_BITS = 24,
  parameter int DUMMY_CYC = `SFIO_READ_DUMMY_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Serial pins, data lines as input, output and output enable
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_dq,
  output logic [3:0] o_dq,
  output logic [3:0] o_dq_oe,
  input wire logic i_reset_pin_n,
  // Configuration bits
  input wire logic i_quad_enable_bit,
  input wire logic i_hold_rst_sel,
  input wire logic [1:0] i_status_protect_bits,
  // Read data from the array side
  input wire logic [7:0] i_rd_byte,
  output logic o_rd_byte_req,
  // Captured command stream
  output logic [7:0] o_opcode,
  output logic o_opcode_valid,
  output logic [7:0] o_wr_byte,
  output logic o_wr_byte_valid,
  output logic [ADDR_BITS-1:0] o_addr,
  output logic o_addr_valid,
  // Status
  output logic o_four_wire_instruction_mode,
  output logic o_status_write_blocked,
  output logic o_paused,
  output logic o_busy,
  output logic o_dev_reset
);
  initial begin
    if (ADDR_BITS % 4 != 0 || ADDR_BITS < 8) $error("ADDR_BITS must be a multiple of 4");
    if (SW_RST_CYC < 1 || DUMMY_CYC < 1) $error("counts must be at least one");
  end

  // ==========================================================
  // Pin synchronisers
  logic [7:0] pins_s;
  // Reset values match idle pins, so no false select fall arms the sequencer
  sfio_sync #(.WIDTH(8), .INIT(8'hcf)) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_reset_pin_n, i_cs_n, i_sclk, 1'b0, i_dq}),
    .o_sync(pins_s)
  );
  logic dedic_rst_n, cs_n, sclk;
  logic [3:0] dq;
  assign dedic_rst_n = pins_s[7];
  assign cs_n = pins_s[6];
  assign sclk = pins_s[5];
  assign dq = pins_s[3:0];

  // ==========================================================
  // Hardware resets
  logic shared_rst_n, dedic_rst, shared_rst, hw_rst;
  // Shared pin is reset only with quad enable clear and select bit set
  assign shared_rst_n = !(!i_quad_enable_bit && i_hold_rst_sel && !dq[3]);
  sfio_rst_filter #(.MIN_CYC(HW_RST_CYC)) u_rst_dedic (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_pin_n(dedic_rst_n),
    .o_reset(dedic_rst)
  );
  sfio_rst_filter #(.MIN_CYC(HW_RST_CYC)) u_rst_shared (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_pin_n(shared_rst_n),
    .o_reset(shared_rst)
  );
  // Overrides every input but those feeding o_status_write_blocked while asserted
  assign hw_rst = dedic_rst || shared_rst;
  assign o_dev_reset = hw_rst;

  // ==========================================================
  // Clock and select edges
  logic sclk_d, cs_n_d, armed;
  logic rise, fall, cs_rise, cs_fall;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk;
      cs_n_d <= cs_n;
    end
  end
  assign cs_rise = cs_n && !cs_n_d;
  assign cs_fall = !cs_n && cs_n_d;

  // Commands only after a select fall seen since reset
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || hw_rst) begin
      armed <= 1'b0;
    end else if (cs_fall) begin
      armed <= 1'b1;
    end
  end

  // ==========================================================
  // Pause
  logic pause_ok, paused;
  // Pause exists only with quad enable clear and the select bit clear
  assign pause_ok = !i_quad_enable_bit && !i_hold_rst_sel;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || hw_rst || cs_n) begin
      paused <= 1'b0;
    end else if (!sclk || (sclk_d && !sclk)) begin
      // Change applies at the pin edge while clock low, else at the next falling clock
      paused <= pause_ok && !dq[3];
    end
  end
  assign o_paused = paused;

  // Clock edges are ignored while paused; mode 0 and 3 both idle safely
  assign rise = sclk && !sclk_d && !cs_n && !paused && armed && !hw_rst;
  assign fall = !sclk && sclk_d && !cs_n && !paused && armed && !hw_rst;

  // ==========================================================
  // Command sequencer
  sfio_phase_t phase;
  sfio_width_t in_w, out_w;
  logic four_wire, busy, rst_armed;
  logic [7:0] sh;
  logic [5:0] bit_cnt;
  logic [$clog2(SW_RST_CYC + 1)-1:0] busy_cnt;
  logic first_edge, out_on;
  logic [7:0] rd_sh;

  function automatic logic [2:0] step(input sfio_width_t w);
    case (w)
      SFIO_W2: step = 3'd2;
      SFIO_W4: step = 3'd4;
      default: step = 3'd1;
    endcase
  endfunction : step

  function automatic logic [7:0] shift_in(input logic [7:0] s, input sfio_width_t w,
                                          input logic [3:0] d);
    case (w)
      SFIO_W2: shift_in = {s[5:0], d[1:0]};
      SFIO_W4: shift_in = {s[3:0], d};
      default: shift_in = {s[6:0], d[0]};
    endcase
  endfunction : shift_in

  logic [7:0] next_sh;
  logic [5:0] next_cnt;
  assign next_sh = shift_in(sh, in_w, dq);
  assign next_cnt = bit_cnt + 6'(step(in_w));

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || hw_rst) begin
      phase <= SFIO_OPC;
      in_w <= SFIO_W1;
      out_w <= SFIO_W1;
      four_wire <= 1'b0;
      sh <= 8'h00;
      bit_cnt <= 6'h00;
      rst_armed <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= '0;
      first_edge <= 1'b1;
      o_opcode <= 8'h00;
      o_opcode_valid <= 1'b0;
      o_wr_byte <= 8'h00;
      o_wr_byte_valid <= 1'b0;
      o_addr <= '0;
      o_addr_valid <= 1'b0;
    end else begin
      o_opcode_valid <= 1'b0;
      o_wr_byte_valid <= 1'b0;
      o_addr_valid <= 1'b0;
      if (busy) begin
        if (busy_cnt == '0) begin
          busy <= 1'b0;
        end else begin
          busy_cnt <= busy_cnt - 1'b1;
        end
      end
      if (cs_n) begin
        // Partial instruction discarded on deselect
        phase <= SFIO_OPC;
        in_w <= four_wire ? SFIO_W4 : SFIO_W1;
        bit_cnt <= 6'h00;
        first_edge <= 1'b1;
        if (cs_rise && phase != SFIO_OPC) begin
          rst_armed <= rst_armed && o_opcode == `SFIO_OP_RST_EN;
        end
      end else if (rise) begin
        sh <= next_sh;
        bit_cnt <= next_cnt;
        first_edge <= 1'b0;
        case (phase)
          SFIO_OPC: begin
            if (next_cnt == 6'd8) begin
              bit_cnt <= 6'h00;
              o_opcode <= next_sh;
              o_opcode_valid <= !busy;
              phase <= SFIO_WDATA;
              rst_armed <= 1'b0;
              if (!busy) begin
                case (next_sh)
                  `SFIO_OP_RST_EN: begin
                    rst_armed <= 1'b1;
                  end
                  `SFIO_OP_RST: begin
                    if (rst_armed) begin
                      // Software reset returns to SPI mode and goes busy
                      four_wire <= 1'b0;
                      busy <= 1'b1;
                      busy_cnt <= ($bits(busy_cnt))'(SW_RST_CYC - 1);
                    end
                    phase <= SFIO_IGNORE;
                  end
                  `SFIO_OP_ENTER_4W: begin
                    if (i_quad_enable_bit) four_wire <= 1'b1;
                    phase <= SFIO_IGNORE;
                  end
                  `SFIO_OP_EXIT_4W: begin
                    four_wire <= 1'b0;
                    phase <= SFIO_IGNORE;
                  end
                  `SFIO_OP_DUAL_OUT: begin
                    phase <= SFIO_ADDR;
                    out_w <= SFIO_W2;
                  end
                  `SFIO_OP_DUAL_IO: begin
                    phase <= SFIO_ADDR;
                    in_w <= SFIO_W2;
                    out_w <= SFIO_W2;
                  end
                  `SFIO_OP_QUAD_OUT, `SFIO_OP_QUAD_IO: begin
                    // Quad reads need quad enable, otherwise the command is dropped
                    if (i_quad_enable_bit) begin
                      phase <= SFIO_ADDR;
                      out_w <= SFIO_W4;
                      if (next_sh == `SFIO_OP_QUAD_IO) in_w <= SFIO_W4;
                    end else begin
                      phase <= SFIO_IGNORE;
                    end
                  end
                  default: begin
                    out_w <= four_wire ? SFIO_W4 : SFIO_W1;
                  end
                endcase
              end else begin
                phase <= SFIO_IGNORE;
              end
            end
          end
          SFIO_ADDR: begin
            o_addr <= (o_addr << step(in_w)) | ADDR_BITS'(
              in_w == SFIO_W4 ? dq : in_w == SFIO_W2 ? {2'b00, dq[1:0]} : {3'b000, dq[0]});
            if (next_cnt == 6'(ADDR_BITS)) begin
              bit_cnt <= 6'h00;
              o_addr_valid <= 1'b1;
              phase <= SFIO_DUMMY;
            end
          end
          SFIO_DUMMY: begin
            if (bit_cnt == 6'(DUMMY_CYC - 1)) begin
              bit_cnt <= 6'h00;
              phase <= SFIO_RDATA;
            end else begin
              bit_cnt <= bit_cnt + 6'd1;
            end
          end
          SFIO_WDATA: begin
            if (next_cnt == 6'd8) begin
              bit_cnt <= 6'h00;
              o_wr_byte <= next_sh;
              o_wr_byte_valid <= 1'b1;
            end
          end
          default: begin
            bit_cnt <= 6'h00;
          end
        endcase
      end
    end
  end

  assign o_four_wire_instruction_mode = four_wire;
  assign o_busy = busy;
  // Write-protect pin gates status writes only while quad enable is clear
  assign o_status_write_blocked = !i_quad_enable_bit && i_status_protect_bits[0] && !dq[2];

  // ==========================================================
  // Read data driver, updated on falling clock
  logic [3:0] rd_cnt;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || hw_rst || cs_n) begin
      out_on <= 1'b0;
      rd_sh <= 8'h00;
      rd_cnt <= 4'h0;
      o_dq <= 4'h0;
      o_rd_byte_req <= 1'b0;
    end else begin
      o_rd_byte_req <= 1'b0;
      if (fall && phase == SFIO_RDATA) begin
        out_on <= 1'b1;
        if (rd_cnt == 4'h0) begin
          rd_sh <= i_rd_byte << step(out_w);
          rd_cnt <= 4'(8 - step(out_w));
          o_rd_byte_req <= 1'b1;
          o_dq <= out_w == SFIO_W4 ? i_rd_byte[7:4] :
                  out_w == SFIO_W2 ? {2'b00, i_rd_byte[7:6]} : {2'b00, i_rd_byte[7], 1'b0};
        end else begin
          rd_sh <= rd_sh << step(out_w);
          rd_cnt <= rd_cnt - 4'(step(out_w));
          o_dq <= out_w == SFIO_W4 ? rd_sh[7:4] :
                  out_w == SFIO_W2 ? {2'b00, rd_sh[7:6]} : {2'b00, rd_sh[7], 1'b0};
        end
      end
    end
  end

  // Lines released when deselected, paused or not returning data
  always_comb begin
    o_dq_oe = 4'h0;
    if (out_on && !cs_n && !paused && phase == SFIO_RDATA) begin
      case (out_w)
        SFIO_W4: o_dq_oe = 4'hf;
        SFIO_W2: o_dq_oe = 4'h3;
        default: o_dq_oe = 4'h2;
      endcase
    end
  end
endmodule : sfio_front

/* hdl/sfio_defines.svh */
// Constants for the serial flash front end: opcodes, timing counts and the read dummy count.
// Assumes a 125 MHz system clock (8 ns period).
`ifndef SFIO_DEFINES_SVH
`define SFIO_DEFINES_SVH

// ==========================================================
// Opcodes
`define SFIO_OP_DUAL_OUT 8'h3b
`define SFIO_OP_DUAL_IO 8'hbb
`define SFIO_OP_QUAD_OUT 8'h6b
`define SFIO_OP_QUAD_IO 8'heb
`define SFIO_OP_ENTER_4W 8'h38
`define SFIO_OP_EXIT_4W 8'hff
`define SFIO_OP_RST_EN 8'h66
`define SFIO_OP_RST 8'h99

// ==========================================================
// Timing
`define SFIO_CLK_NS 8
`define SFIO_SW_RST_NS 30000
`define SFIO_SW_RST_CYC ((`SFIO_SW_RST_NS) / (`SFIO_CLK_NS))
`define SFIO_HW_RST_NS 1000
`define SFIO_HW_RST_CYC (((`SFIO_HW_RST_NS) + (`SFIO_CLK_NS) - 1) / (`SFIO_CLK_NS))

// ==========================================================
// Read dummy cycles
`define SFIO_READ_DUMMY_CYC 8

`endif

/* hdl/sfio_pkg.sv */
// Types shared by the serial flash front end.
// Needs nothing beyond the tool's SystemVerilog support.
package sfio_pkg;
  typedef enum logic [1:0] {
    SFIO_W1,
    SFIO_W2,
    SFIO_W4
  } sfio_width_t;

  typedef enum logic [2:0] {
    SFIO_OPC,
    SFIO_ADDR,
    SFIO_DUMMY,
    SFIO_RDATA,
    SFIO_WDATA,
    SFIO_IGNORE
  } sfio_phase_t;
endpackage : sfio_pkg

/* hdl/sfio_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to i_mclk.
`timescale 1ns/100ps
module sfio_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta <= INIT;
      o_sync <= INIT;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : sfio_sync

/* hdl/sfio_rst_filter.sv */
// Hardware reset pin filter: a low level held long enough becomes a reset level.
// Assumes the pin input is already synchronised to i_mclk.
`timescale 1ns/100ps
`include "sfio_defines.svh"
module sfio_rst_filter #(
  parameter int MIN_CYC = `SFIO_HW_RST_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Pin level, low asks for reset
  input wire logic i_pin_n,
  output logic o_reset
);
  localparam int CW = $clog2(MIN_CYC + 1);
  logic [CW-1:0] cnt;

  initial begin
    if (MIN_CYC < 1) $error("MIN_CYC must be at least one");
  end

  // Short glitches do not reset; a held low does, and reset stays while low
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt <= '0;
      o_reset <= 1'b0;
    end else if (i_pin_n) begin
      cnt <= '0;
      o_reset <= 1'b0;
    end else if (cnt != CW'(MIN_CYC)) begin
      cnt <= cnt + CW'(1);
    end else begin
      o_reset <= 1'b1;
    end
  end
endmodule : sfio_rst_filter

/* tb/sfio_front_props.sv */
// Checker for the serial flash front end, bound into the front end.
// Assumes quad enable and pin select bits only change while deselected.
`timescale 1ns/100ps
module sfio_front_props #(
  parameter int SW_RST_CYC = 20,
  parameter int HW_RST_CYC = 4
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Pins and configuration
  input wire logic i_cs_n,
  input wire logic [3:0] i_dq,
  input wire logic [3:0] o_dq_oe,
  input wire logic i_reset_pin_n,
  input wire logic i_quad_enable_bit,
  input wire logic i_hold_rst_sel,
  input wire logic [1:0] i_status_protect_bits,
  // Results
  input wire logic [7:0] o_opcode,
  input wire logic o_opcode_valid,
  input wire logic o_four_wire_instruction_mode,
  input wire logic o_status_write_blocked,
  input wire logic o_paused,
  input wire logic o_busy,
  input wire logic o_dev_reset
);
  // ==========
  // Helpers
  logic [15:0] busy_cnt;
  logic wp_block;
  logic rst_req;
  assign wp_block = !i_quad_enable_bit && i_status_protect_bits[0] && !i_dq[2];
  assign rst_req = !i_reset_pin_n || (i_hold_rst_sel && !i_quad_enable_bit && !i_dq[3]);
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !o_busy)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= busy_cnt + 16'h0001;
  end
  // ==========
  // Properties
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_desel_lines_free: assert property (i_cs_n [*5] |-> o_dq_oe == 4'h0)
    else $error("data lines driven while deselected");
  a_pause_lines_free: assert property (o_paused |-> o_dq_oe == 4'h0)
    else $error("data lines driven during pause");
  a_pause_only_hold: assert property ($rose(o_paused) |-> !i_quad_enable_bit && !i_hold_rst_sel)
    else $error("pause with pin not in pause role");
  a_quad_needs_qe: assert property (o_dq_oe[3] |-> i_quad_enable_bit)
    else $error("line three driven without quad enable");
  a_oe_patterns: assert property (o_dq_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal output enable pattern");
  a_fw_entry: assert property ($rose(o_four_wire_instruction_mode) |-> i_quad_enable_bit && o_opcode == 8'h38)
    else $error("four-wire entry without cause");
  a_fw_exit: assert property ($fell(o_four_wire_instruction_mode) |->
    o_opcode inside {8'hff, 8'h99} || o_dev_reset || $past(o_dev_reset))
    else $error("four-wire exit without cause");
  a_busy_cause: assert property ($rose(o_busy) |-> o_opcode == 8'h99)
    else $error("busy without reset opcode");
  a_busy_length: assert property ($fell(o_busy) && !o_dev_reset |->
    busy_cnt >= SW_RST_CYC && busy_cnt <= SW_RST_CYC + 2)
    else $error("software reset period length wrong");
  a_busy_refuses: assert property (o_busy && $past(o_busy) |-> !o_opcode_valid)
    else $error("opcode taken while busy");
  a_hw_rst_quiet: assert property (o_dev_reset |-> !o_opcode_valid && o_dq_oe == 4'h0)
    else $error("activity during hardware reset");
  a_hw_rst_min: assert property ($rose(o_dev_reset) |-> $past(rst_req, HW_RST_CYC))
    else $error("hardware reset on short pulse");
  a_wp_blocks: assert property (wp_block [*4] |-> o_status_write_blocked)
    else $error("status write not blocked");
  a_qe_frees_wp: assert property (i_quad_enable_bit [*4] |-> !o_status_write_blocked)
    else $error("status write blocked in quad");
  c_pause: cover property ($rose(o_paused));
  c_busy: cover property ($fell(o_busy));
  c_fw: cover property ($rose(o_four_wire_instruction_mode));
  c_hw: cover property ($rose(o_dev_reset));
endmodule : sfio_front_props

bind sfio_front sfio_front_props #(.SW_RST_CYC(SW_RST_CYC), .HW_RST_CYC(HW_RST_CYC)) u_props (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_dq(i_dq), .o_dq_oe(o_dq_oe),
  .i_reset_pin_n(i_reset_pin_n), .i_quad_enable_bit(i_quad_enable_bit),
  .i_hold_rst_sel(i_hold_rst_sel), .i_status_protect_bits(i_status_protect_bits),
  .o_opcode(o_opcode), .o_opcode_valid(o_opcode_valid),
  .o_four_wire_instruction_mode(o_four_wire_instruction_mode),
  .o_status_write_blocked(o_status_write_blocked), .o_paused(o_paused),
  .o_busy(o_busy), .o_dev_reset(o_dev_reset));

/* tb/sfio_host_model.sv */
// Host controller model driving the flash pins in clock mode 0.
// Assumes the bench resolves line levels and feeds them back on i_dq.
`timescale 1ns/100ps
module sfio_host_model (
  // Clock
  input wire logic i_mclk,
  // Pins
  input wire logic [3:0] i_dq,
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_dq,
  output logic [3:0] o_dq_oe
);
  logic hold_n = 1'b1;
  logic wp_n = 1'b1;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_dq = 4'h0;
    o_dq_oe = 4'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick
  task automatic set_ctl(input logic h, input logic w);
    hold_n = h;
    wp_n = w;
    o_dq[3:2] = {h, w};
    o_dq_oe[3:2] = 2'b11;
    tick(6);
  endtask : set_ctl
  // One 64 ns clock; read back late in the high half, where device data has settled
  task automatic clk_one(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] q);
    o_dq = d;
    o_dq_oe = oe;
    o_sclk = 1'b0;
    tick(4);
    o_sclk = 1'b1;
    tick(3);
    q = i_dq;
    tick(1);
  endtask : clk_one
  task automatic shift(input logic [7:0] b, input int lanes, input logic rd, output logic [7:0] r);
    logic [3:0] m;
    logic [3:0] c;
    logic [3:0] q;
    m = 4'((1 << lanes) - 1);
    c = (lanes == 4) ? 4'h0 : {hold_n, wp_n, 2'b00};
    r = 8'h00;
    for (int i = 0; i < 8 / lanes; i++) begin
      clk_one(4'(b >> (8 - lanes * (i + 1))) & m | c, (rd ? 4'h0 : m) | (lanes == 4 ? 4'h0 : 4'hc),
              q);
      r = 8'((r << lanes) | (q & m));
    end
  endtask : shift
  task automatic start();
    o_cs_n = 1'b0;
    tick(4);
  endtask : start
  task automatic stop();
    o_sclk = 1'b0;
    tick(4);
    o_cs_n = 1'b1;
    o_dq_oe = 4'h0;
    tick(8);
  endtask : stop
endmodule : sfio_host_model

/* tb/testbench.sv */
// Self-checking bench: host model on the pins, queued expectations for captured fields.
// Assumes shortened reset counts; unused lines 0 and 1 alternate every cycle, lines 2 and 3 sit high.
`timescale 1ns/100ps
`include "sfio_defines.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
  import sfio_pkg::*;
  localparam int SW_CYC = 200;
  localparam int HW_CYC = 8;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_reset_pin_n = 1'b1;
  logic i_qe = 1'b0;
  logic i_sel = 1'b0;
  logic [1:0] i_spb = 2'b00;
  logic [7:0] i_rd_byte = 8'h00;
  logic cs_n, sclk, tog = 1'b0;
  logic [3:0] h_dq, h_oe, o_dq, o_oe, dq_w, q;
  logic [7:0] o_opcode, o_wr_byte, e8, rb, r, w;
  logic [23:0] o_addr, e24, a;
  logic o_req, o_opv, o_wrv, o_adv, o_fw, o_swb, o_paused, o_busy, o_dev_reset;
  int fails = 0, num_checks = 0, cycles = 0, seed = 54324, nreq = 0;
  logic [7:0] exp_op[$], exp_wr[$];
  logic [23:0] exp_ad[$];
  logic [7:0] rops[4] = '{`SFIO_OP_DUAL_OUT, `SFIO_OP_DUAL_IO, `SFIO_OP_QUAD_OUT, `SFIO_OP_QUAD_IO};
  int alanes[4] = '{1, 2, 1, 4};
  int dlanes[4] = '{2, 2, 4, 4};
  initial forever #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) tog <= ~tog;
  // Line 2 and 3 carry pull-ups; the others float to a changing pattern
  assign dq_w = o_oe & o_dq | ~o_oe & (h_oe & h_dq | ~h_oe & {2'b11, tog, ~tog});
  sfio_front #(.SW_RST_CYC(SW_CYC), .HW_RST_CYC(HW_CYC)) dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_dq(dq_w),
    .o_dq(o_dq), .o_dq_oe(o_oe), .i_reset_pin_n(i_reset_pin_n), .i_quad_enable_bit(i_qe),
    .i_hold_rst_sel(i_sel), .i_status_protect_bits(i_spb), .i_rd_byte(i_rd_byte),
    .o_rd_byte_req(o_req), .o_opcode(o_opcode), .o_opcode_valid(o_opv), .o_wr_byte(o_wr_byte),
    .o_wr_byte_valid(o_wrv), .o_addr(o_addr), .o_addr_valid(o_adv),
    .o_four_wire_instruction_mode(o_fw), .o_status_write_blocked(o_swb),
    .o_paused(o_paused), .o_busy(o_busy), .o_dev_reset(o_dev_reset));
  sfio_host_model host (.i_mclk(i_mclk), .i_dq(dq_w), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_dq(h_dq), .o_dq_oe(h_oe));
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic op(input logic [7:0] o, input int l, input logic push);
    host.start();
    if (push)
      exp_op.push_back(o);
    host.shift(o, l, 1'b0, r);
  endtask : op
  task automatic frame(input logic [7:0] o, input int l, input logic push);
    op(o, l, push);
    host.stop();
  endtask : frame
  // ==========
  // Result watcher
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles > 30000) begin
      fails++;
      give_verdict();
    end
    if (o_req === 1'b1)
      nreq++;
    if (o_opv !== 1'b0) begin
      e8 = exp_op.size() ? exp_op.pop_front() : 8'hxx;
      `CHK("opcode", e8, o_opcode)
    end
    if (o_wrv !== 1'b0) begin
      e8 = exp_wr.size() ? exp_wr.pop_front() : 8'hxx;
      `CHK("write byte", e8, o_wr_byte)
    end
    if (o_adv !== 1'b0) begin
      e24 = exp_ad.size() ? exp_ad.pop_front() : 24'hxxxxxx;
      `CHK("address", e24, o_addr)
    end
  end
  // ==========
  // Scenarios
  initial begin
    repeat (6) @(posedge i_mclk);
    #1 i_rst_n = 1'b1;
    host.tick(4);
    `CHK("mode after reset", 1'b0, o_fw)
    op(8'h02, 1, 1);
    w = 8'($random(seed));
    exp_wr.push_back(w);
    host.shift(w, 1, 1'b0, r);
    host.set_ctl(1'b0, 1'b1);
    `CHK("pause waits for fall", 1'b0, o_paused)
    host.o_sclk = 1'b0;
    host.tick(6);
    `CHK("paused", 1'b1, o_paused)
    repeat (3) host.clk_one({3'b010, 1'($random(seed))}, 4'hd, q);
    host.set_ctl(1'b1, 1'b1);
    `CHK("pause holds", 1'b1, o_paused)
    host.o_sclk = 1'b0;
    host.tick(6);
    `CHK("pause ended", 1'b0, o_paused)
    w = 8'($random(seed));
    exp_wr.push_back(w);
    host.shift(w, 1, 1'b0, r);
    host.stop();
    $display("Test write and pause finished");
    i_qe = 1'b1;
    for (int k = 0; k < 4; k++) begin
      rb = 8'($random(seed));
      a = 24'($random(seed));
      i_rd_byte = rb;
      op(rops[k], 1, 1);
      exp_ad.push_back(a);
      for (int j = 2; j >= 0; j--)
        host.shift(a[j * 8 +: 8], alanes[k], 1'b0, r);
      host.shift(8'h00, 1, 1'b1, r);
      repeat (2) begin
        host.shift(8'h00, dlanes[k], 1'b1, r);
        `CHK("read byte", rb, r)
      end
      host.stop();
    end
    // Two bytes read per command, a third started by the closing clock fall
    `CHK("byte requests", 12, nreq)
    $display("Test reads finished");
    i_qe = 1'b0;
    frame(`SFIO_OP_ENTER_4W, 1, 1);
    `CHK("entry refused", 1'b0, o_fw)
    i_qe = 1'b1;
    frame(`SFIO_OP_ENTER_4W, 1, 1);
    `CHK("entry", 1'b1, o_fw)
    frame(8'h02, 4, 1);
    frame(`SFIO_OP_EXIT_4W, 4, 1);
    `CHK("exit", 1'b0, o_fw)
    frame(`SFIO_OP_RST_EN, 1, 1);
    frame(8'h02, 1, 1);
    frame(`SFIO_OP_RST, 1, 1);
    `CHK("split reset ignored", 1'b0, o_busy)
    frame(`SFIO_OP_ENTER_4W, 1, 1);
    frame(`SFIO_OP_RST_EN, 4, 1);
    frame(`SFIO_OP_RST, 4, 1);
    `CHK("busy", 1'b1, o_busy)
    frame(8'h02, 1, 0);
    for (int t = 0; t < SW_CYC + 50 && o_busy !== 1'b0; t++)
      host.tick(1);
    `CHK("busy over", 1'b0, o_busy)
    `CHK("back to SPI", 1'b0, o_fw)
    frame(8'h02, 1, 1);
    $display("Test modes and software reset finished");
    i_sel = 1'b1;
    i_qe = 1'b0;
    host.set_ctl(1'b0, 1'b1);
    host.set_ctl(1'b1, 1'b1);
    `CHK("short pulse", 1'b0, o_dev_reset)
    host.set_ctl(1'b0, 1'b1);
    host.tick(8);
    `CHK("pin reset", 1'b1, o_dev_reset)
    i_qe = 1'b1;
    host.tick(16);
    `CHK("quad frees pin", 1'b0, o_dev_reset)
    host.set_ctl(1'b1, 1'b1);
    frame(`SFIO_OP_ENTER_4W, 1, 1);
    host.start();
    i_reset_pin_n = 1'b0;
    host.tick(HW_CYC + 8);
    `CHK("dedicated reset", 1'b1, o_dev_reset)
    `CHK("mode reset", 1'b0, o_fw)
    i_reset_pin_n = 1'b1;
    host.tick(4);
    host.stop();
    for (int k = 0; k < 8; k++) begin
      i_qe = k[0];
      i_sel = 1'($random(seed));
      i_reset_pin_n = k[0] | k[2];
      i_spb = {1'($random(seed)), k[1]};
      host.set_ctl(1'b1, k[2]);
      `CHK("status block", !k[0] && k[1] && !k[2], o_swb)
      `CHK("short dedicated pulse", 1'b0, o_dev_reset)
    end
    $display("Test resets and protect finished");
    give_verdict();
  end
endmodule : testbench
